/* File: mcpc_consts.svh */
// Purpose: offsets, packet bit counts and codes of the control packet codec
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes: included by the codec module and the bench
`ifndef MCPC_CONSTS_SVH
`define MCPC_CONSTS_SVH

`define MCPC_ADDR_W 6
`define MCPC_OFS_CTRL 6'h00
`define MCPC_OFS_STATUS 6'h04
`define MCPC_OFS_FC_CFG 6'h08
`define MCPC_OFS_SG_CFG0 6'h0c
`define MCPC_OFS_SG_CFG1 6'h10
`define MCPC_OFS_KA_CFG 6'h14
`define MCPC_OFS_RX_HI 6'h18
`define MCPC_OFS_RX_LO 6'h1c
`define MCPC_OFS_RX_CLASS 6'h20

`define MCPC_CTYPE_FRAME_CHANGE 3'h5
`define MCPC_CTYPE_SLOT_GRANT 3'h6
`define MCPC_CTYPE_KEEPALIVE 3'h7

`define MCPC_FC_LEAD_PATTERN 2'h2
`define MCPC_OP_ALLOC 2'h0
`define MCPC_OP_DEALLOC 2'h1
`define MCPC_OP_RELOCATE 2'h2

`define MCPC_FC_BITS 6'h18
`define MCPC_SG_BITS 6'h30
`define MCPC_KA_BITS 6'h18

`define MCPC_RESP_OKAY 2'h0
`define MCPC_RESP_SLVERR 2'h2

`endif

/* File: mcpc_pkg.sv */
// Purpose: types of the control packet codec
// Assumes: constants come from mcpc_consts.svh
// Notes: no imports; users write mcpc_pkg::name
package mcpc_pkg;

    typedef enum logic [1:0]
    {
        KIND_FRAME_CHANGE,
        KIND_SLOT_GRANT,
        KIND_KEEPALIVE,
        KIND_NONE
    } mcpc_kind_t;

    typedef enum logic [3:0]
    {
        CLS_NONE,
        CLS_FRAME_CHANGE,
        CLS_ALLOCATION_REQUEST,
        CLS_ALLOCATION_INDICATION,
        CLS_ALLOCATION_REJECTION,
        CLS_DEALLOCATION_REQUEST,
        CLS_DEALLOCATION_CONFIRM,
        CLS_GRANT_RELOCATION_INDICATION,
        CLS_KEEPALIVE_REQUEST,
        CLS_KEEPALIVE_ACK,
        CLS_INVALID
    } mcpc_class_t;

    typedef enum logic
    {
        TX_IDLE,
        TX_SHIFT
    } mcpc_tx_state_t;

endpackage

/* File: mcpc_codec.sv */
// Purpose: build, serialize and classify MAC control packets
// Assumes: AXI4-Lite master on i_sys_clk; serial sink on the same clock
// Notes: packets leave msb first on o_tx_bit while i_tx_ready is high
//
// Behaviour
// R1: frame change packets use control type 5
// R2: frame change leads with fixed bits 10
// R3: next frame length coded like attribute
// R4: legacy phy flag set in compatibility mode
// R5: legacy flag forces compatible frames elsewhere
// R6: frame change reserved bits sent as zero
// R7: ten-bit contention free offset from frame start
// R8: five-bit beacon sequence marks change moment
// R9: slot grant packets use control type 6
// R10: direction bit 0 uplink, 1 downlink
// R11: nine-bit connection identifier carried
// R12: seven-bit grant length in symbols
// R13: nine-bit grant position in symbols
// R14: operation 0 alloc, 1 dealloc, 2 relocate
// R15: fourteen-bit local node identifier carried
// R16: accept flag 1 marks accepted request
// R17: request uses operation 0, origin bit 0
// R18: operation 0 origin 1 is allocation indication
// R19: rejection is operation 0 origin 1
// R20: dealloc request origin 0, confirm origin 1
// R21: operation 2 origin 1 is relocation
// R22: keepalive packets use control type 7
// R23: keepalive flag 1 request, 0 acknowledge
// R24: attempt sequence restarts zero, increments per repeat
// R25: accept flag splits indication from rejection
// R26: fields sent msb first in listed order
`timescale 1ns/1ns
`include "mcpc_consts.svh"

module mcpc_codec
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [`MCPC_ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [`MCPC_ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_tx_bit,
    output logic o_tx_valid,
    output logic o_tx_last,
    output logic [2:0] o_tx_control_type,
    input wire logic i_tx_ready,
    output logic o_legacy_phy_flag,
    output logic [1:0] o_next_frame_length
);

    // register storage
    logic [31:0] fc_cfg;
    logic [31:0] sg_cfg0;
    logic [31:0] sg_cfg1;
    logic [31:0] ka_cfg;
    logic [31:0] rx_hi;
    logic [31:0] rx_lo;
    logic [2:0] tx_attempt_seq;
    logic decode_pending;
    mcpc_pkg::mcpc_class_t rx_class;
    logic legacy_phy_flag;
    logic [1:0] next_frame_length;

    // write channel capture
    logic aw_held;
    logic w_held;
    logic [`MCPC_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;

    assign o_awready = !aw_held && !o_bvalid;
    assign o_wready = !w_held && !o_bvalid;
    assign wr_fire = aw_held && w_held && !o_bvalid;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (i_awvalid && o_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
        end
        else if (wr_fire)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (i_wvalid && o_wready)
        begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
        end
        else if (wr_fire)
        begin
            w_held <= 1'b0;
        end
    end

    logic wr_mapped;
    always_comb
    begin
        unique case (aw_addr)
            `MCPC_OFS_CTRL, `MCPC_OFS_FC_CFG, `MCPC_OFS_SG_CFG0,
            `MCPC_OFS_SG_CFG1, `MCPC_OFS_KA_CFG, `MCPC_OFS_RX_HI,
            `MCPC_OFS_RX_LO: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_bvalid <= 1'b0;
            o_bresp <= `MCPC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_mapped ? `MCPC_RESP_OKAY : `MCPC_RESP_SLVERR;
        end
        else if (i_bready)
        begin
            o_bvalid <= 1'b0;
        end
    end

    function automatic logic [31:0] merge
    (
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic wr_hit(input logic [`MCPC_ADDR_W-1:0] ofs);
        return wr_fire && aw_addr == ofs;
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            fc_cfg <= '0;
            sg_cfg0 <= '0;
            sg_cfg1 <= '0;
            ka_cfg <= '0;
            rx_hi <= '0;
            rx_lo <= '0;
        end
        else
        begin
            if (wr_hit(`MCPC_OFS_FC_CFG))
                fc_cfg <= merge(fc_cfg, w_data, w_strb);
            if (wr_hit(`MCPC_OFS_SG_CFG0))
                sg_cfg0 <= merge(sg_cfg0, w_data, w_strb);
            if (wr_hit(`MCPC_OFS_SG_CFG1))
                sg_cfg1 <= merge(sg_cfg1, w_data, w_strb);
            if (wr_hit(`MCPC_OFS_KA_CFG))
                ka_cfg <= merge(ka_cfg, w_data, w_strb);
            if (wr_hit(`MCPC_OFS_RX_HI))
                rx_hi <= merge(rx_hi, w_data, w_strb);
            if (wr_hit(`MCPC_OFS_RX_LO))
                rx_lo <= merge(rx_lo, w_data, w_strb);
        end
    end

    // control word: bit0 send, bit1 new keepalive operation, bits 3:2 kind
    logic ctrl_write;
    logic send_req;
    logic ka_new_op;
    mcpc_pkg::mcpc_kind_t send_kind;
    // written out: a continuous assign does not wake on function globals
    assign ctrl_write = wr_fire && aw_addr == `MCPC_OFS_CTRL && w_strb[0];
    assign send_req = ctrl_write && w_data[0];
    assign ka_new_op = ctrl_write && w_data[1];
    assign send_kind = mcpc_pkg::mcpc_kind_t'(w_data[3:2]);

    // packet assembly, fields msb first in listed order [R26]
    logic [47:0] fc_word;
    logic [47:0] sg_word;
    logic [47:0] ka_word;
    assign fc_word = {`MCPC_FC_LEAD_PATTERN,     // [R2]
                      fc_cfg[1:0],               // [R3]
                      fc_cfg[2],                 // [R4]
                      1'b0,                      // [R6]
                      fc_cfg[12:3],              // [R7]
                      fc_cfg[17:13],             // [R8]
                      3'h0,                      // [R6]
                      24'h000000};
    assign sg_word = {sg_cfg0[0],                // [R16]
                      sg_cfg0[1],                // [R10]
                      sg_cfg0[6:2],              // [R8]
                      sg_cfg0[15:7],             // [R11]
                      sg_cfg0[22:16],            // [R12]
                      sg_cfg1[8:0],              // [R13]
                      sg_cfg0[24:23],            // [R14]
                      sg_cfg1[22:9]};            // [R15]
    assign ka_word = {ka_cfg[0],                 // [R23]
                      ka_cfg[4:1],
                      ka_cfg[7:5],
                      ka_cfg[13:8],
                      2'h0,
                      (ka_new_op ? 3'h0 : tx_attempt_seq), // [R24]
                      5'h00,
                      24'h000000};

    // serializer
    mcpc_pkg::mcpc_tx_state_t tx_state;
    logic [47:0] tx_shift;
    logic [5:0] tx_left;
    logic tx_take;
    assign tx_take = tx_state == mcpc_pkg::TX_SHIFT && i_tx_ready;
    assign o_tx_valid = tx_state == mcpc_pkg::TX_SHIFT;
    assign o_tx_bit = tx_shift[47];
    assign o_tx_last = o_tx_valid && tx_left == 6'h01;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_state <= mcpc_pkg::TX_IDLE;
            tx_shift <= '0;
            tx_left <= '0;
            o_tx_control_type <= 3'h0;
        end
        else
        begin
            unique case (tx_state)
                mcpc_pkg::TX_IDLE:
                begin
                    if (send_req && send_kind != mcpc_pkg::KIND_NONE)
                    begin
                        tx_state <= mcpc_pkg::TX_SHIFT;
                        unique case (send_kind)
                            mcpc_pkg::KIND_FRAME_CHANGE:
                            begin
                                tx_shift <= fc_word;
                                tx_left <= `MCPC_FC_BITS;
                                o_tx_control_type <=
                                    `MCPC_CTYPE_FRAME_CHANGE; // [R1]
                            end
                            mcpc_pkg::KIND_SLOT_GRANT:
                            begin
                                tx_shift <= sg_word;
                                tx_left <= `MCPC_SG_BITS;
                                o_tx_control_type <=
                                    `MCPC_CTYPE_SLOT_GRANT; // [R9]
                            end
                            default:
                            begin
                                tx_shift <= ka_word;
                                tx_left <= `MCPC_KA_BITS;
                                o_tx_control_type <=
                                    `MCPC_CTYPE_KEEPALIVE; // [R22]
                            end
                        endcase
                    end
                end
                mcpc_pkg::TX_SHIFT:
                begin
                    if (tx_take)
                    begin
                        tx_shift <= {tx_shift[46:0], 1'b0}; // [R26]
                        tx_left <= tx_left - 6'h01;
                        if (tx_left == 6'h01)
                            tx_state <= mcpc_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    // attempt counter: new operation restarts it only in TX_IDLE, each keepalive send bumps
    logic ka_sent;
    assign ka_sent = tx_take && tx_left == 6'h01 &&
                     o_tx_control_type == `MCPC_CTYPE_KEEPALIVE;
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            tx_attempt_seq <= 3'h0;
        else if (ka_new_op && tx_state == mcpc_pkg::TX_IDLE)
            tx_attempt_seq <= 3'h0; // [R24]
        else if (ka_sent)
            tx_attempt_seq <= tx_attempt_seq + 3'h1; // [R24]
    end

    // decoder: rx_hi holds bits 47:16, rx_lo 15:0, type 18:16, origin 19
    logic [47:0] rx_word;
    logic [2:0] rx_ctype;
    logic rx_origin;
    assign rx_word = {rx_hi, rx_lo[15:0]};
    assign rx_ctype = rx_lo[18:16];
    assign rx_origin = rx_lo[19];

    mcpc_pkg::mcpc_class_t next_class;
    always_comb
    begin
        next_class = mcpc_pkg::CLS_INVALID;
        unique case (rx_ctype)
            `MCPC_CTYPE_FRAME_CHANGE:
            begin
                if (rx_word[47:46] == `MCPC_FC_LEAD_PATTERN &&
                    !rx_word[42] && rx_word[26:24] == 3'h0) // [R2] [R6]
                    next_class = mcpc_pkg::CLS_FRAME_CHANGE;
            end
            `MCPC_CTYPE_SLOT_GRANT:
            begin
                unique case ({rx_word[15:14], rx_origin}) // [R26]
                    {`MCPC_OP_ALLOC, 1'b0}:
                        next_class = mcpc_pkg::CLS_ALLOCATION_REQUEST; // [R17]
                    {`MCPC_OP_ALLOC, 1'b1}:
                        next_class = rx_word[47] ? // [R25]
                            mcpc_pkg::CLS_ALLOCATION_INDICATION : // [R18]
                            mcpc_pkg::CLS_ALLOCATION_REJECTION; // [R19]
                    {`MCPC_OP_DEALLOC, 1'b0}:
                        next_class =
                            mcpc_pkg::CLS_DEALLOCATION_REQUEST; // [R20]
                    {`MCPC_OP_DEALLOC, 1'b1}:
                        next_class =
                            mcpc_pkg::CLS_DEALLOCATION_CONFIRM; // [R20]
                    {`MCPC_OP_RELOCATE, 1'b1}:
                        next_class =
                            mcpc_pkg::CLS_GRANT_RELOCATION_INDICATION; // [R21]
                    default:
                        next_class = mcpc_pkg::CLS_INVALID;
                endcase
            end
            `MCPC_CTYPE_KEEPALIVE:
            begin
                next_class = rx_word[47] ? // [R23]
                    mcpc_pkg::CLS_KEEPALIVE_REQUEST :
                    mcpc_pkg::CLS_KEEPALIVE_ACK;
            end
            default:
                next_class = mcpc_pkg::CLS_INVALID;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            decode_pending <= 1'b0;
        else
            decode_pending <= wr_hit(`MCPC_OFS_RX_LO);
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rx_class <= mcpc_pkg::CLS_NONE;
            legacy_phy_flag <= 1'b0;
            next_frame_length <= 2'h0;
        end
        else if (decode_pending)
        begin
            rx_class <= next_class;
            if (next_class == mcpc_pkg::CLS_FRAME_CHANGE)
            begin
                legacy_phy_flag <= rx_word[43]; // [R4] [R5]
                next_frame_length <= rx_word[45:44]; // [R3]
            end
        end
    end

    assign o_legacy_phy_flag = legacy_phy_flag;
    assign o_next_frame_length = next_frame_length;

    // read channel
    logic [31:0] rd_word;
    logic rd_mapped;
    always_comb
    begin
        rd_mapped = 1'b1;
        unique case (i_araddr)
            `MCPC_OFS_CTRL: rd_word = 32'h00000000;
            `MCPC_OFS_STATUS: rd_word = {27'h0, tx_attempt_seq,
                                         decode_pending, o_tx_valid};
            `MCPC_OFS_FC_CFG: rd_word = fc_cfg;
            `MCPC_OFS_SG_CFG0: rd_word = sg_cfg0;
            `MCPC_OFS_SG_CFG1: rd_word = sg_cfg1;
            `MCPC_OFS_KA_CFG: rd_word = ka_cfg;
            `MCPC_OFS_RX_HI: rd_word = rx_hi;
            `MCPC_OFS_RX_LO: rd_word = rx_lo;
            `MCPC_OFS_RX_CLASS: rd_word = {25'h0, next_frame_length,
                                           legacy_phy_flag, rx_class};
            default:
            begin
                rd_word = 32'h00000000;
                rd_mapped = 1'b0;
            end
        endcase
    end

    assign o_arready = !o_rvalid;
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= `MCPC_RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= rd_mapped ? `MCPC_RESP_OKAY : `MCPC_RESP_SLVERR;
        end
        else if (i_rready)
        begin
            o_rvalid <= 1'b0;
        end
    end

endmodule

/* File: mcpc_codec_assertions.sv */
// Purpose: concurrent checks on the codec serial output
// Assumes: bound to every mcpc_codec instance
// Notes: pos counts bits already taken in the current packet
`timescale 1ns/1ns
module mcpc_codec_assertions
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic o_tx_bit,
    input wire logic o_tx_valid,
    input wire logic o_tx_last,
    input wire logic [2:0] o_tx_control_type,
    input wire logic i_tx_ready
);
    logic [5:0] pos;
    logic [5:0] top;
    logic [2:0] ty;
    assign ty = o_tx_control_type;
    assign top = (ty == 3'h6) ? 6'h2f : 6'h17;
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            pos <= 6'h00;
        else if (!o_tx_valid)
            pos <= 6'h00;
        else if (i_tx_ready)
            pos <= pos + 6'h01;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    AST_TX_HOLD:
        assert property (o_tx_valid && !i_tx_ready |=>
            o_tx_valid && $stable(o_tx_bit))
        else $error("serial bit moved while stalled");
    AST_TX_LAST:
        assert property (o_tx_valid |-> o_tx_last == (pos == top))
        else $error("last flag at wrong bit");
    AST_TX_END:
        assert property (o_tx_valid && o_tx_last && i_tx_ready |=>
            !o_tx_valid)
        else $error("packet runs past last bit");
    AST_TYPE_OK:
        assert property (o_tx_valid |-> ty inside {3'h5, 3'h6, 3'h7})
        else $error("illegal control type sent");
    AST_TYPE_HOLD:
        assert property (o_tx_valid && $past(o_tx_valid) |-> $stable(ty))
        else $error("control type changed mid packet");
    AST_FC_LEAD:
        assert property (o_tx_valid && ty == 3'h5 && pos < 6'h02 |->
            o_tx_bit == (pos == 6'h00))
        else $error("frame change lead pattern wrong");
    AST_FC_ZERO:
        assert property (o_tx_valid && ty == 3'h5 &&
            (pos == 6'h05 || pos > 6'h14) |-> !o_tx_bit)
        else $error("frame change reserved bit set");
    AST_KA_ZERO:
        assert property (o_tx_valid && ty == 3'h7 &&
            (pos == 6'h0e || pos == 6'h0f || pos > 6'h12) |-> !o_tx_bit)
        else $error("keepalive reserved bit set");
endmodule

bind mcpc_codec mcpc_codec_assertions chk_u
(
    .i_sys_clk,
    .i_rstn,
    .o_tx_bit,
    .o_tx_valid,
    .o_tx_last,
    .o_tx_control_type,
    .i_tx_ready
);

/* File: mcpc_sink_model.sv */
// Purpose: serial sink standing beyond the codec transmitter
// Assumes: one bit taken per edge with valid and ready high
// Notes: slow mode stalls on a fixed irregular pattern
`timescale 1ns/1ns
module mcpc_sink_model
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_slow,
    input wire logic i_tx_bit,
    input wire logic i_tx_valid,
    input wire logic i_tx_last,
    output logic o_ready,
    output logic [47:0] o_pkt,
    output logic [5:0] o_cnt
);
    logic [2:0] phase;
    logic inpkt;
    assign o_ready = !i_slow || phase == 3'h2 || phase[2];
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase <= 3'h0;
            inpkt <= 1'b0;
            o_pkt <= 48'h0;
            o_cnt <= 6'h00;
        end
        else
        begin
            phase <= phase + 3'h1;
            if (i_tx_valid && o_ready)
            begin
                // first bit lands lowest, later bits push it up
                o_pkt <= {inpkt ? o_pkt[46:0] : 47'h0, i_tx_bit};
                o_cnt <= inpkt ? o_cnt + 6'h01 : 6'h01;
                inpkt <= !i_tx_last;
            end
        end
    end
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench for the control packet codec
// Assumes: AXI4-Lite master tasks, sink model on the serial side
// Notes: expected packets are assembled here from field values
`timescale 1ns/1ns
`include "mcpc_consts.svh"
module tb_top;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [5:0] i_awaddr = 6'h00;
    logic i_awvalid = 1'b0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hf;
    logic i_wvalid = 1'b0;
    logic i_bready = 1'b0;
    logic [5:0] i_araddr = 6'h00;
    logic i_arvalid = 1'b0;
    logic i_rready = 1'b0;
    logic slow = 1'b0;
    logic i_tx_ready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp, o_next_frame_length;
    logic [31:0] o_rdata, d;
    logic o_tx_bit, o_tx_valid, o_tx_last, o_legacy_phy_flag;
    logic [2:0] o_tx_control_type;
    logic [47:0] pkt;
    logic [5:0] cnt;
    logic [1:0] r;
    int bad_count = 0;
    int checks = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    mcpc_codec dut_u
    (
        .i_sys_clk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
        .o_rresp, .o_rvalid, .i_rready, .o_tx_bit, .o_tx_valid,
        .o_tx_last, .o_tx_control_type, .i_tx_ready,
        .o_legacy_phy_flag, .o_next_frame_length
    );
    mcpc_sink_model sink_u
    (
        .i_sys_clk, .i_rstn, .i_slow(slow), .i_tx_bit(o_tx_bit),
        .i_tx_valid(o_tx_valid), .i_tx_last(o_tx_last),
        .o_ready(i_tx_ready), .o_pkt(pkt), .o_cnt(cnt)
    );
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge i_sys_clk);
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        forever
        begin
            @(posedge i_sys_clk);
            if (i_awvalid && o_awready)
                i_awvalid <= 1'b0;
            if (i_wvalid && o_wready)
                i_wvalid <= 1'b0;
            if (o_bvalid && i_bready)
            begin
                r = o_bresp;
                i_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge i_sys_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        forever
        begin
            @(posedge i_sys_clk);
            if (i_arvalid && o_arready)
                i_arvalid <= 1'b0;
            if (o_rvalid && i_rready)
            begin
                d = o_rdata;
                r = o_rresp;
                i_rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic wait_tx();
        do
            @(negedge i_sys_clk);
        while (o_tx_valid);
    endtask
    task automatic dec(input logic [31:0] hi, input logic dn,
        input logic [2:0] ty, input logic [1:0] op, input logic [3:0] c);
        wr(`MCPC_OFS_RX_HI, hi);
        wr(`MCPC_OFS_RX_LO, {12'h0, dn, ty, op, 14'h0});
        repeat (2) @(posedge i_sys_clk);
        rd(`MCPC_OFS_RX_CLASS);
        chk(d[3:0], c);
    endtask
    task automatic print_verdict();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        repeat (12) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        wr(`MCPC_OFS_FC_CFG, {14'h0, 5'h13, 10'h2a5, 1'b1, 2'h1});
        rd(`MCPC_OFS_FC_CFG);
        chk({d, r}, {14'h0, 5'h13, 10'h2a5, 1'b1, 2'h1, 2'h0});
        wr(`MCPC_OFS_CTRL, 32'h1);
        wait_tx();
        chk(pkt[23:0], {4'h9, 2'h2, 10'h2a5, 5'h13, 3'h0});
        chk(cnt, 6'h18);
        chk(o_tx_control_type, 3'h5);
        // byte strobes: only the low byte may change
        @(posedge i_sys_clk);
        i_wstrb <= 4'h1;
        wr(`MCPC_OFS_FC_CFG, 32'hffffffff);
        i_wstrb <= 4'hf;
        rd(`MCPC_OFS_FC_CFG);
        chk(d, {14'h0, 5'h13, 10'h2a5, 1'b1, 2'h1} | 32'hff);
        wr(`MCPC_OFS_SG_CFG0, {7'h0, 2'h2, 7'h3c, 9'h155, 5'h0a, 2'h3});
        wr(`MCPC_OFS_SG_CFG1, {9'h0, 14'h2d61, 9'h0f3});
        @(posedge i_sys_clk);
        slow <= 1'b1;
        wr(`MCPC_OFS_CTRL, 32'h5);
        rd(`MCPC_OFS_STATUS);
        chk(d[0], 1'b1);
        // a send while busy must be dropped
        wr(`MCPC_OFS_CTRL, 32'h1);
        wait_tx();
        chk(pkt, {2'h3, 5'h0a, 9'h155, 7'h3c, 9'h0f3, 2'h2, 14'h2d61});
        chk(cnt, 6'h30);
        chk(o_tx_control_type, 3'h6);
        repeat (4) @(negedge i_sys_clk);
        chk(o_tx_valid, 1'b0);
        wr(`MCPC_OFS_KA_CFG, {18'h0, 6'h2b, 3'h5, 4'h9, 1'b1});
        // third send restarts a fresh operation after two attempts
        for (int k = 0; k < 3; k++)
        begin
            wr(`MCPC_OFS_CTRL, k == 1 ? 32'h9 : 32'hb);
            wait_tx();
            chk(pkt[23:0], {1'b1, 4'h9, 3'h5, 6'h2b, 2'h0, 3'(k % 2),
                5'h0});
            chk(o_tx_control_type, 3'h7);
        end
        rd(`MCPC_OFS_STATUS);
        chk(d[4:2], 3'h1);
        wr(`MCPC_OFS_CTRL, 32'h2);
        rd(`MCPC_OFS_STATUS);
        chk(d[4:2], 3'h0);
        rd(6'h3c);
        chk({d, r}, {32'h0, 2'h2});
        wr(6'h24, 32'h1);
        chk(r, 2'h2);
        // kind 3 must not start a packet
        wr(`MCPC_OFS_CTRL, 32'hd);
        rd(`MCPC_OFS_STATUS);
        chk(d[0], 1'b0);
        dec({4'h9, 2'h2, 10'h3ff, 5'h1f, 3'h0, 8'h0}, 1'b1, 3'h5,
            2'h0, 4'h1);
        chk(d[6:4], 3'h3);
        dec(32'h20000000, 1'b1, 3'h5, 2'h0, 4'ha);
        dec(32'ha4000000, 1'b1, 3'h5, 2'h0, 4'ha);
        dec(32'h80000100, 1'b1, 3'h5, 2'h0, 4'ha);
        chk({o_legacy_phy_flag, o_next_frame_length}, 3'h5);
        dec(32'h0, 1'b0, 3'h6, 2'h0, 4'h2);
        dec(32'h80000000, 1'b1, 3'h6, 2'h0, 4'h3);
        dec(32'h0, 1'b1, 3'h6, 2'h0, 4'h4);
        dec(32'h0, 1'b0, 3'h6, 2'h1, 4'h5);
        dec(32'h0, 1'b1, 3'h6, 2'h1, 4'h6);
        dec(32'h0, 1'b1, 3'h6, 2'h2, 4'h7);
        dec(32'h0, 1'b0, 3'h6, 2'h2, 4'ha);
        dec(32'h0, 1'b1, 3'h6, 2'h3, 4'ha);
        dec(32'h80000000, 1'b0, 3'h7, 2'h0, 4'h8);
        dec(32'h0, 1'b0, 3'h7, 2'h0, 4'h9);
        dec(32'h0, 1'b0, 3'h4, 2'h0, 4'ha);
        print_verdict();
    end
endmodule
